// ==== tb_top.sv ====
// Self-checking testbench for the watchdog and low-power controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import wdlp_pkg::*;
    // ==========================================================
    // Signals
    localparam int PULSE_N = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wdlp_bus_req_s bus = '0;
    logic [31:0] rdata;
    logic idle_exec = 1'b0;
    logic int_taken;
    logic nmi_n = 1'b1;
    logic dbg_n = 1'b1;
    logic [31:0] porta = 32'hffff_ffff;
    logic [31:0] pin_in = 32'h0;
    logic [31:0] pin_out;
    logic wd_rst_n;
    logic wd_int_n;
    wdlp_clk_gate_s gate;
    logic [2:0] state;
    logic irq_req = 1'b0;
    logic [3:0] lat = 4'h2;
    int n_mismatch = 0;
    int total_checks = 0;

    always #10 clk = ~clk;

    wdlp_top #(.PULSE_CYCLES(PULSE_N)) i_dut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .BUS_I(bus), .RDATA_O(rdata),
        .IDLE_EXEC_I(idle_exec), .CPU_INT_TAKEN_I(int_taken),
        .EXTERNAL_NONMASKABLE_IRQ_N_I(nmi_n), .DEBUG_WAKE_N_I(dbg_n), .PORTA_I(porta),
        .PIN_OUT_I(pin_in), .PIN_OUT_O(pin_out), .WATCHDOG_RESET_N_O(wd_rst_n),
        .WATCHDOG_WAKE_INTERRUPT_N_O(wd_int_n), .CLK_GATE_O(gate), .STATE_O(state)
    );

    wdlp_cpu_model i_cpu (
        .clk_i(clk), .rst_n_i(rst_n), .state_i(state), .wd_int_n_i(wd_int_n),
        .nmi_n_i(nmi_n), .irq_req_i(irq_req), .lat_i(lat), .int_taken_o(int_taken)
    );

    // ==========================================================
    // Shared tasks
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task step;
        @(posedge clk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task key;
        wr(WD_KEY_OFS, 32'h55);
        wr(WD_KEY_OFS, 32'haa);
    endtask

    task enter(input logic [7:0] ctrl);
        wr(LP_CTRL0_OFS, {24'h0, ctrl});
        @(posedge clk);
        idle_exec <= 1'b1;
        @(posedge clk);
        idle_exec <= 1'b0;
        step();
    endtask

    task wait_st(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim)
        begin
            step();
            n++;
        end
        chk(32'(state), 32'(s), "state");
    endtask

    // ==========================================================
    // Scenarios
    task t_reset;
        logic [7:0] ofs [5] = '{WD_CTRL_OFS, WD_KEY_OFS, LP_CTRL0_OFS, WAKE_SEL_OFS, 8'h20};
        logic [31:0] d;
        chk(32'(state), 32'(ST_RUN), "reset state");
        chk(32'(gate), 32'h7, "reset gates");
        chk({30'h0, wd_rst_n, wd_int_n}, 32'h3, "watchdog outputs");
        wr(8'h20, 32'hffff_ffff);
        foreach (ofs[i])
        begin
            rd(ofs[i], d);
            chk(d, 32'h0, "reset read");
        end
        $display("t_reset done");
    endtask

    task t_key;
        logic [31:0] d;
        key();
        rd(WD_COUNT_OFS, d);
        chk(32'(d[7:0] < 8'h4), 32'h1, "count cleared");
        repeat (100) step();
        wr(WD_KEY_OFS, 32'h55);
        wr(WD_KEY_OFS, 32'h12);
        wr(WD_KEY_OFS, 32'haa);
        rd(WD_COUNT_OFS, d);
        chk(32'(d[7:0] > 8'h60), 32'h1, "broken key kept count");
        $display("t_key done");
    endtask

    task t_wd_pulse;
        int n;
        logic [31:0] d;
        wr(WD_CTRL_OFS, 32'h0);
        key();
        n = 0;
        while (wd_rst_n !== 1'b0 && n < 300)
        begin
            step();
            n++;
        end
        chk(32'(wd_rst_n), 32'h0, "reset pulse start");
        chk(32'(wd_int_n), 32'h1, "interrupt quiet");
        rd(WD_COUNT_OFS, d);
        chk(32'(d[WD_PULSE_BIT]), 32'h1, "pulse flag");
        n = 0;
        while (wd_rst_n === 1'b0 && n < 20)
        begin
            step();
            n++;
        end
        chk(32'(n + 2), 32'(PULSE_N), "pulse width");
        $display("t_wd_pulse done");
    endtask

    task t_wd_disable;
        logic [31:0] a;
        logic [31:0] b;
        logic bad;
        wr(WD_CTRL_OFS, 32'h1);
        rd(WD_COUNT_OFS, a);
        bad = 1'b0;
        repeat (300)
        begin
            step();
            if (wd_rst_n !== 1'b1)
                bad = 1'b1;
        end
        rd(WD_COUNT_OFS, b);
        chk(b, a, "count frozen");
        chk(32'(bad), 32'h0, "no pulse");
        $display("t_wd_disable done");
    endtask

    task t_standby_wd;
        @(posedge clk);
        pin_in <= 32'h1234_5678;
        wr(WD_CTRL_OFS, 32'h2);
        key();
        enter(8'h01);
        chk(32'(state), 32'(ST_STANDBY), "standby");
        chk(32'(gate), 32'h4, "standby gates");
        @(posedge clk);
        pin_in <= 32'hffff_0000;
        step();
        chk(pin_out, 32'h1234_5678, "pins held");
        wait_st(ST_WAKE, 300);
        wait_st(ST_RUN, 20);
        repeat (3) step();
        chk(pin_out, 32'hffff_0000, "pins follow");
        wr(WD_CTRL_OFS, 32'h1);
        repeat (10) step();
        $display("t_standby_wd done");
    endtask

    task t_idle;
        for (int src = 0; src < 3; src++)
        begin
            if (src == 2)
            begin
                wr(WD_CTRL_OFS, 32'h2);
                key();
            end
            enter(8'h00);
            chk(32'(state), 32'(ST_IDLE), "idle");
            chk(32'(gate), 32'h7, "idle gates");
            repeat (20) step();
            chk(32'(state), 32'(ST_IDLE), "idle stays");
            @(posedge clk);
            irq_req <= (src == 0);
            nmi_n <= (src != 1);
            wait_st(ST_RUN, 300);
            @(posedge clk);
            irq_req <= 1'b0;
            nmi_n <= 1'b1;
            wr(WD_CTRL_OFS, 32'h1);
        end
        $display("t_idle done");
    endtask

    task t_standby_pin;
        int n;
        wr(WAKE_SEL_OFS, 32'h10);
        enter(8'h0d);
        @(posedge clk);
        porta <= 32'hffff_fffe;
        repeat (20) step();
        chk(32'(state), 32'(ST_STANDBY), "unselected pin");
        @(posedge clk);
        porta <= 32'hffff_ffef;
        @(posedge clk);
        @(posedge clk);
        porta <= 32'hffff_ffff;
        repeat (10) step();
        chk(32'(state), 32'(ST_STANDBY), "short glitch");
        @(posedge clk);
        lat <= 4'hf;
        porta <= 32'hffff_ffef;
        n = 0;
        while (state !== ST_WAKE && n < 12)
        begin
            step();
            n++;
        end
        chk(32'(state), 32'(ST_WAKE), "pin wake");
        chk(32'(n >= 3), 32'h1, "qualified delay");
        @(posedge clk);
        porta <= 32'hffff_ffff;
        wait_st(ST_STANDBY, 6);
        @(posedge clk);
        lat <= 4'h1;
        nmi_n <= 1'b0;
        wait_st(ST_RUN, 20);
        @(posedge clk);
        nmi_n <= 1'b1;
        $display("t_standby_pin done");
    endtask

    task t_halt;
        logic [31:0] a;
        logic [31:0] b;
        for (int m = 2; m < 4; m++)
        begin
            wr(WD_CTRL_OFS, 32'h2);
            key();
            enter(8'(m));
            chk(32'(state), 32'(ST_HALT), "halt");
            chk(32'(gate), 32'h0, "halt gates");
            rd(LP_STATUS_OFS, a);
            chk(a, 32'(ST_HALT), "status halt");
            rd(WD_COUNT_OFS, a);
            repeat (300) step();
            chk(32'(state), 32'(ST_HALT), "no watchdog wake");
            rd(WD_COUNT_OFS, b);
            chk(b, a, "watchdog frozen");
            @(posedge clk);
            porta <= (m == 2) ? 32'hffff_ffef : 32'hffff_ffff;
            dbg_n <= (m == 2);
            wait_st(ST_WAKE, 5);
            wait_st(ST_RUN, 10);
            @(posedge clk);
            porta <= 32'hffff_ffff;
            dbg_n <= 1'b1;
            wr(WD_CTRL_OFS, 32'h1);
        end
        $display("t_halt done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        step();
        t_reset();
        t_key();
        t_wd_pulse();
        t_wd_disable();
        t_standby_wd();
        t_idle();
        t_standby_pin();
        t_halt();
        end_sim();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("CHECK FAILED at %0t: timeout", $time);
        end_sim();
    end
endmodule
`default_nettype wire

// ==== wdlp_cpu_model.sv ====
// Behavioural model of the CPU core and interrupt expander
`timescale 1ns/1ps
`default_nettype none
module wdlp_cpu_model
    import wdlp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Controller view
    input wire logic [2:0] state_i,
    input wire logic wd_int_n_i,
    input wire logic nmi_n_i,
    input wire logic irq_req_i,
    // Recognition latency in cycles
    input wire logic [3:0] lat_i,
    // Interrupt recognised
    output logic int_taken_o
);
    // ==========================================================
    // Interrupt recognition
    logic [3:0] wait_reg;
    logic pending;

    // Wake sources must stay low until recognised
    assign pending = (state_i == 3'(ST_IDLE) && (!wd_int_n_i || !nmi_n_i || irq_req_i))
        || state_i == 3'(ST_WAKE);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_reg <= 4'h0;
            int_taken_o <= 1'b0;
        end
        else
        begin
            int_taken_o <= 1'b0;
            if (pending && !int_taken_o)
            begin
                if (wait_reg == lat_i)
                begin
                    int_taken_o <= 1'b1;
                    wait_reg <= 4'h0;
                end
                else
                begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end
            else
            begin
                wait_reg <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== wdlp_pkg.sv ====
// Constants and types shared by the watchdog and low-power controller
package wdlp_pkg;

    // ==========================================================
    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } wdlp_bus_req_s;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] WD_CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] WD_KEY_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] WD_COUNT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] LP_CTRL0_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] WAKE_SEL_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] LP_STATUS_OFS = 8'h14;

    // ==========================================================
    // Field positions and reset values
    localparam int WD_DIS_BIT = 0;
    localparam int WD_INTMODE_BIT = 1;
    localparam int WD_PULSE_BIT = 8;
    localparam int LP_MODE_LSB = 0;
    localparam int LP_QUAL_LSB = 2;
    localparam int LP_QUAL_W = 6;
    localparam logic [1:0] WD_CTRL_RST = 2'h0;
    localparam logic [1:0] LP_MODE_RST = 2'h0;
    localparam logic [LP_QUAL_W-1:0] LP_QUAL_RST = 6'h00;
    localparam logic [31:0] WAKE_SEL_RST = 32'h0000_0000;

    // ==========================================================
    // Watchdog key values and timing
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam int WD_PULSE_CYCLES = 512;

    // ==========================================================
    // Clock gate outputs and controller states
    typedef struct packed {
        logic osc_en;
        logic cpu_en;
        logic sys_en;
    } wdlp_clk_gate_s;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE,
        ST_STANDBY,
        ST_HALT,
        ST_WAKE
    } wdlp_state_e;

endpackage

// ==== wdlp_top.sv ====
// Watchdog timer and low-power mode controller
//
// Notes on behaviour
// R1: 8-bit up counter; max value fires 512-cycle pulse
// R2: Key 0x55 then 0xAA clears the counter
// R3: Disabled counter neither advances nor pulses
// R4: Reset output low 512 cycles on overflow
// R5: Watchdog runs on oscillator clock, also standby
// R6: Watchdog interrupt feeds wake logic for standby
// R7: Watchdog interrupt reaches CPU via interrupt expander
// R8: Halt stops oscillator; watchdog frozen, no wake
// R9: Mode field: 00 idle, 01 standby, 1X halt
// R10: Clock enables per mode as tabled
// R11: Idle exits on reset, watchdog, interrupt, NMI
// R12: Standby exits on reset, watchdog, pins, debugger, NMI
// R13: Halt exits on reset, pins, NMI, debugger only
// R14: Wake low must persist, else mode resumes
// R15: Idle left only on processor interrupt recognition
// R16: Only selected port A pins wake
// R17: Standby pin wake qualified over programmed cycles
// R18: Halt uses same wake pin select register
// R19: Output pins hold state during low power
// R20: Debug wake works with CPU clock stopped
// R21: Wrong key between 0x55 and 0xAA restarts
`timescale 1ns/1ps
`default_nettype none
module wdlp_top
#(
    parameter int WD_W = 8,
    parameter int PULSE_CYCLES = wdlp_pkg::WD_PULSE_CYCLES
)
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // Register bus
    input wire wdlp_pkg::wdlp_bus_req_s BUS_I,
    output logic [wdlp_pkg::DATA_W-1:0] RDATA_O,
    // CPU side
    input wire logic IDLE_EXEC_I,
    input wire logic CPU_INT_TAKEN_I,
    // Wake sources, active low
    input wire logic EXTERNAL_NONMASKABLE_IRQ_N_I,
    input wire logic DEBUG_WAKE_N_I,
    input wire logic [31:0] PORTA_I,
    // Output pin hold path
    input wire logic [31:0] PIN_OUT_I,
    output logic [31:0] PIN_OUT_O,
    // Watchdog outputs
    output logic WATCHDOG_RESET_N_O,
    output logic WATCHDOG_WAKE_INTERRUPT_N_O,
    // Clock gating
    output wdlp_pkg::wdlp_clk_gate_s CLK_GATE_O,
    output logic [2:0] STATE_O
);
    import wdlp_pkg::*;

    localparam int PC_W = $clog2(PULSE_CYCLES + 1);
    localparam logic [WD_W-1:0] WD_MAX = {WD_W{1'b1}};
    localparam logic [PC_W-1:0] PULSE_LOAD = PC_W'(PULSE_CYCLES);

    if (WD_W < 2 || WD_W > WD_PULSE_BIT || PULSE_CYCLES < 1)
    begin
        $error("wdlp_top: unsupported parameter values");
    end

    // ==========================================================
    // Decoding helpers
    function automatic wdlp_state_e mode_target(input logic [1:0] m);
        mode_target = m[1] ? ST_HALT : (m[0] ? ST_STANDBY : ST_IDLE);
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] ofs, input logic [ADDR_W-1:0] a);
        hit = (a == ofs);
    endfunction

    // ==========================================================
    // Registers
    logic wd_dis_reg;
    logic wd_intmode_reg;
    logic [1:0] mode_reg;
    logic [LP_QUAL_W-1:0] qual_reg;
    logic [31:0] wake_sel_reg;
    logic [WD_W-1:0] count_reg;
    logic key_armed_reg;
    logic [PC_W-1:0] pulse_reg;
    logic [LP_QUAL_W:0] qcnt_reg;
    wdlp_state_e state_reg;
    wdlp_state_e ret_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [31:0] pin_reg;

    logic halted;
    logic pulse_on;
    logic key_wr;
    logic key_done;
    logic ovf_start;
    logic pins_low;
    logic qual_ok;
    logic standby_wake;
    logic halt_wake;

    assign halted = (state_reg == ST_HALT) || (state_reg == ST_WAKE && ret_reg == ST_HALT);
    assign pulse_on = (pulse_reg != '0);
    assign key_wr = BUS_I.wr && hit(WD_KEY_OFS, BUS_I.addr);
    assign key_done = key_wr && key_armed_reg && BUS_I.wdata[7:0] == KEY_SECOND; // [R2]

    // ==========================================================
    // Control register writes
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wd_dis_reg <= WD_CTRL_RST[WD_DIS_BIT];
            wd_intmode_reg <= WD_CTRL_RST[WD_INTMODE_BIT];
            mode_reg <= LP_MODE_RST;
            qual_reg <= LP_QUAL_RST;
            wake_sel_reg <= WAKE_SEL_RST;
        end
        else if (BUS_I.wr)
        begin
            if (hit(WD_CTRL_OFS, BUS_I.addr))
            begin
                wd_dis_reg <= BUS_I.wdata[WD_DIS_BIT];
                wd_intmode_reg <= BUS_I.wdata[WD_INTMODE_BIT];
            end
            if (hit(LP_CTRL0_OFS, BUS_I.addr))
            begin
                mode_reg <= BUS_I.wdata[LP_MODE_LSB +: 2];
                qual_reg <= BUS_I.wdata[LP_QUAL_LSB +: LP_QUAL_W];
            end
            if (hit(WAKE_SEL_OFS, BUS_I.addr))
            begin
                wake_sel_reg <= BUS_I.wdata; // [R16] [R18]
            end
        end
    end

    // ==========================================================
    // Key sequence recognition
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            key_armed_reg <= 1'b0;
        end
        else if (key_wr)
        begin
            key_armed_reg <= (BUS_I.wdata[7:0] == KEY_FIRST); // [R21]
        end
    end

    // ==========================================================
    // Watchdog counter, frozen while the oscillator is off
    assign ovf_start = !wd_dis_reg && !halted && count_reg == WD_MAX && !pulse_on; // [R1] [R3]

    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            count_reg <= '0;
        end
        else if (key_done)
        begin
            count_reg <= '0; // [R2]
        end
        else if (!wd_dis_reg && !halted)
        begin
            count_reg <= count_reg + 1'b1; // [R1] [R5] [R8]
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pulse_reg <= '0;
        end
        else if (ovf_start)
        begin
            pulse_reg <= PULSE_LOAD; // [R1] [R4]
        end
        else if (pulse_on && !halted)
        begin
            pulse_reg <= pulse_reg - 1'b1;
        end
    end

    assign WATCHDOG_RESET_N_O = !(pulse_on && !wd_intmode_reg); // [R4]
    assign WATCHDOG_WAKE_INTERRUPT_N_O = !(pulse_on && wd_intmode_reg); // [R6] [R7]

    // ==========================================================
    // Wake pin qualification
    assign pins_low = |(wake_sel_reg & ~PORTA_I); // [R16]
    assign qual_ok = pins_low && (qcnt_reg >= {1'b0, qual_reg}); // [R17]

    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            qcnt_reg <= '0;
        end
        else if (!pins_low)
        begin
            qcnt_reg <= '0;
        end
        else if (qcnt_reg <= {1'b0, qual_reg})
        begin
            qcnt_reg <= qcnt_reg + 1'b1; // [R17]
        end
    end

    assign standby_wake = !WATCHDOG_WAKE_INTERRUPT_N_O || qual_ok
        || !DEBUG_WAKE_N_I || !EXTERNAL_NONMASKABLE_IRQ_N_I; // [R6] [R12] [R20]
    assign halt_wake = pins_low || !DEBUG_WAKE_N_I
        || !EXTERNAL_NONMASKABLE_IRQ_N_I; // [R13] [R18] [R20]

    // ==========================================================
    // Low-power state machine
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_reg <= ST_RUN; // [R11] [R12] [R13]
            ret_reg <= ST_RUN;
        end
        else
        begin
            unique case (state_reg)
                ST_RUN:
                begin
                    if (IDLE_EXEC_I)
                    begin
                        state_reg <= mode_target(mode_reg); // [R9]
                        ret_reg <= mode_target(mode_reg);
                    end
                end
                ST_IDLE:
                begin
                    if (CPU_INT_TAKEN_I)
                    begin
                        state_reg <= ST_RUN; // [R11] [R15]
                    end
                end
                ST_STANDBY:
                begin
                    if (standby_wake)
                    begin
                        state_reg <= ST_WAKE; // [R12]
                    end
                end
                ST_HALT:
                begin
                    if (halt_wake)
                    begin
                        state_reg <= ST_WAKE; // [R13]
                    end
                end
                ST_WAKE:
                begin
                    if (CPU_INT_TAKEN_I)
                    begin
                        state_reg <= ST_RUN;
                    end
                    else if (ret_reg == ST_HALT ? !halt_wake : !standby_wake)
                    begin
                        state_reg <= ret_reg; // [R14]
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Clock enables
    always_comb
    begin
        CLK_GATE_O.osc_en = (state_reg != ST_HALT); // [R8] [R10]
        CLK_GATE_O.cpu_en = (state_reg != ST_STANDBY) && (state_reg != ST_HALT); // [R10]
        CLK_GATE_O.sys_en = (state_reg != ST_STANDBY) && (state_reg != ST_HALT);
    end

    assign STATE_O = state_reg;

    // ==========================================================
    // Output pins held outside run
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pin_reg <= '0;
        end
        else if (state_reg == ST_RUN && !IDLE_EXEC_I)
        begin
            pin_reg <= PIN_OUT_I; // [R19]
        end
    end

    assign PIN_OUT_O = pin_reg;

    // ==========================================================
    // Register reads
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rdata_reg <= '0;
        end
        else
        begin
            rdata_reg <= '0;
            if (BUS_I.rd)
            begin
                if (hit(WD_CTRL_OFS, BUS_I.addr))
                begin
                    rdata_reg[WD_DIS_BIT] <= wd_dis_reg;
                    rdata_reg[WD_INTMODE_BIT] <= wd_intmode_reg;
                end
                if (hit(WD_COUNT_OFS, BUS_I.addr))
                begin
                    rdata_reg[WD_W-1:0] <= count_reg;
                    rdata_reg[WD_PULSE_BIT] <= pulse_on;
                end
                if (hit(LP_CTRL0_OFS, BUS_I.addr))
                begin
                    rdata_reg[LP_MODE_LSB +: 2] <= mode_reg;
                    rdata_reg[LP_QUAL_LSB +: LP_QUAL_W] <= qual_reg;
                end
                if (hit(WAKE_SEL_OFS, BUS_I.addr))
                begin
                    rdata_reg <= wake_sel_reg;
                end
                if (hit(LP_STATUS_OFS, BUS_I.addr))
                begin
                    rdata_reg[2:0] <= state_reg;
                end
            end
        end
    end

    assign RDATA_O = rdata_reg;

    // ==========================================================
    // Assertions
    logic [PC_W:0] lowrun_reg;

    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            lowrun_reg <= '0;
        end
        else if (pulse_on)
        begin
            lowrun_reg <= lowrun_reg + 1'b1;
        end
        else
        begin
            lowrun_reg <= '0;
        end
    end

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);

    key_clear_a: assert property (key_done |=> count_reg == '0) // [R2]
        else $error("Key sequence did not clear counter");
    key_restart_a: assert property (key_wr && BUS_I.wdata[7:0] != KEY_FIRST // [R21]
        |=> !key_armed_reg)
        else $error("Wrong key left sequence armed");
    disabled_hold_a: assert property (wd_dis_reg && !key_done |=> $stable(count_reg)) // [R3]
        else $error("Disabled counter moved");
    overflow_pulse_a: assert property (ovf_start |=> pulse_reg == PULSE_LOAD) // [R1]
        else $error("Overflow did not start pulse");
    pulse_width_a: assert property (pulse_on && !halted ##1 !pulse_on // [R4]
        |-> $past(lowrun_reg) + 1'b1 >= PC_W'(PULSE_CYCLES))
        else $error("Watchdog pulse shorter than required");
    mode_decode_a: assert property (state_reg == ST_RUN && IDLE_EXEC_I && mode_reg == 2'h1 // [R9]
        |=> state_reg == ST_STANDBY)
        else $error("Standby code not decoded");
    standby_clk_a: assert property (state_reg == ST_STANDBY // [R10]
        |-> CLK_GATE_O.osc_en && !CLK_GATE_O.cpu_en && !CLK_GATE_O.sys_en)
        else $error("Standby clock gating wrong");
    halt_freeze_a: assert property (state_reg == ST_HALT && !key_done // [R8]
        |=> $stable(count_reg))
        else $error("Watchdog advanced in halt");
    idle_stay_a: assert property (state_reg == ST_IDLE && !CPU_INT_TAKEN_I // [R15]
        |=> state_reg == ST_IDLE)
        else $error("Idle left without interrupt recognition");
    pin_hold_a: assert property (state_reg != ST_RUN |=> $stable(PIN_OUT_O)) // [R19]
        else $error("Output pins changed in low power");

    enter_standby_c: cover property (state_reg == ST_STANDBY ##[1:50] state_reg == ST_WAKE);
    halt_wake_c: cover property (state_reg == ST_HALT ##1 state_reg == ST_WAKE);
    wd_reset_c: cover property ($fell(WATCHDOG_RESET_N_O));
    key_feed_c: cover property (key_done);

endmodule
`default_nettype wire
